//--- verilog/dwg_write_guard.sv
`timescale 1ns/10ps
`default_nettype none

module dwg_write_guard (
   // Clock and reset.
   input wire logic i_mclk,
   input wire logic i_rst,
   // Register port.
   input wire logic [31:0] i_addr,
   input wire logic [31:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [31:0] o_rdata,
   // Protected configuration towards the controller.
   output logic [2:0] o_mem_device,
   output logic o_bus_16bit,
   output logic o_no_anticip_read,
   // Protection state and interrupt.
   output logic o_protect_on,
   output logic o_irq
);

   // ----------------------------------------------------------------
   // Address decode
   // ----------------------------------------------------------------

   // One-hot selects; each is qualified by a strobe where used.
   wire logic sel_memdev;
   wire logic sel_hispeed;
   wire logic sel_mode;
   wire logic sel_stat;
   wire logic sel_irq_stat;
   wire logic sel_irq_mask;
   assign sel_memdev = (i_addr == dwg_pkg::MEMDEV_ADDR);
   assign sel_hispeed = (i_addr == dwg_pkg::HISPEED_ADDR);
   assign sel_mode = (i_addr == dwg_pkg::PROT_MODE_ADDR);
   assign sel_stat = (i_addr == dwg_pkg::PROT_STAT_ADDR);
   assign sel_irq_stat = (i_addr == dwg_pkg::IRQ_STAT_ADDR);
   assign sel_irq_mask = (i_addr == dwg_pkg::IRQ_MASK_ADDR);

   // A protected register is any of the controller configuration words.
   wire logic sel_protected;
   assign sel_protected = sel_memdev | sel_hispeed;

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   logic prot_en_q;
   logic prot_en_d;
   logic viol_flag_q;
   logic viol_flag_d;
   logic [15:0] viol_src_q;
   logic [15:0] viol_src_d;
   logic [2:0] memdev_q;
   logic busw_q;
   logic noantic_q;
   logic [0:0] irq_stat_q;
   logic [0:0] irq_stat_d;
   logic [0:0] irq_mask_q;
   logic [31:0] rdata_q;
   logic [31:0] rdata_d;

   // ----------------------------------------------------------------
   // Protection mode
   // ----------------------------------------------------------------

   // The key must match in full; any other value leaves the enable as is.
   wire logic key_ok;
   wire logic mode_wr_keyed;
   assign key_ok = (i_wdata[dwg_pkg::KEY_LSB +: dwg_pkg::KEY_W]
                    == dwg_pkg::KEY_PASSWORD);
   assign mode_wr_keyed = i_wr & sel_mode & key_ok;

   // Keyed write loads the enable bit, one or zero alike.
   assign prot_en_d = mode_wr_keyed ? i_wdata[dwg_pkg::PROT_EN_BIT]
                                    : prot_en_q;

   // ----------------------------------------------------------------
   // Protected configuration writes
   // ----------------------------------------------------------------

   // A write while protection is on is dropped and counted as a violation.
   wire logic prot_wr;
   wire logic cfg_wr_ok;
   wire logic viol_event;
   assign prot_wr = i_wr & sel_protected;
   assign cfg_wr_ok = prot_wr & ~prot_en_q;
   assign viol_event = prot_wr & prot_en_q;

   // The source is the offset of the target word from the controller base.
   wire logic [31:0] addr_offset;
   assign addr_offset = i_addr - dwg_pkg::CTRL_BASE;

   // ----------------------------------------------------------------
   // Violation status
   // ----------------------------------------------------------------

   // The read strobe clears the status, but a fresh violation wins, so an
   // event in the clearing cycle is never lost. The read and the refused write
   // need different addresses on this one port, so the overlap cannot occur.
   wire logic stat_rd;
   assign stat_rd = i_rd & sel_stat;
   assign viol_flag_d = viol_event ? 1'b1
                      : (stat_rd ? 1'b0 : viol_flag_q);
   assign viol_src_d = viol_event ? addr_offset[15:0]
                     : (stat_rd ? 16'h0000 : viol_src_q);

   // ----------------------------------------------------------------
   // Interrupt
   // ----------------------------------------------------------------

   // Sticky bit, cleared by writing a one; a same-cycle event keeps it set.
   wire logic irq_clr;
   assign irq_clr = i_wr & sel_irq_stat & i_wdata[dwg_pkg::IRQ_VIOL_BIT];
   assign irq_stat_d[0] = viol_event | (irq_stat_q[0] & ~irq_clr);
   assign o_irq = |(irq_stat_q & irq_mask_q);

   // ----------------------------------------------------------------
   // Read data
   // ----------------------------------------------------------------

   // Images of each register; unused bits and the key read as zero.
   wire logic [31:0] img_memdev;
   wire logic [31:0] img_hispeed;
   wire logic [31:0] img_mode;
   wire logic [31:0] img_stat;
   wire logic [31:0] img_irq_stat;
   wire logic [31:0] img_irq_mask;
   assign img_memdev = {27'h0, busw_q, 1'b0, memdev_q};
   assign img_hispeed = {29'h0, noantic_q, 2'h0};
   assign img_mode = {31'h0, prot_en_q};
   assign img_stat = {8'h00, viol_src_q, 7'h0, viol_flag_q};
   assign img_irq_stat = {31'h0, irq_stat_q};
   assign img_irq_mask = {31'h0, irq_mask_q};

   // Unmapped addresses answer zero; the strobe gates the answer.
   assign rdata_d = !i_rd ? 32'h00000000
                  : sel_memdev ? img_memdev
                  : sel_hispeed ? img_hispeed
                  : sel_mode ? img_mode
                  : sel_stat ? img_stat
                  : sel_irq_stat ? img_irq_stat
                  : sel_irq_mask ? img_irq_mask
                  : 32'h00000000;

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------

   // Protection and status state.
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         prot_en_q <= dwg_pkg::PROT_EN_RESET;
         viol_flag_q <= 1'b0;
         viol_src_q <= 16'h0000;
         irq_stat_q <= 1'h0;
      end else begin
         prot_en_q <= prot_en_d;
         viol_flag_q <= viol_flag_d;
         viol_src_q <= viol_src_d;
         irq_stat_q <= irq_stat_d;
      end
   end

   // Protected configuration; only accepted writes reach these.
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         memdev_q <= dwg_pkg::MEMDEV_RESET;
         busw_q <= dwg_pkg::BUSW_RESET;
         noantic_q <= dwg_pkg::NOANTIC_RESET;
      end else if (cfg_wr_ok && sel_memdev) begin
         memdev_q <= i_wdata[dwg_pkg::MEMDEV_LSB +: dwg_pkg::MEMDEV_W];
         busw_q <= i_wdata[dwg_pkg::BUSW_BIT];
      end else if (cfg_wr_ok && sel_hispeed) begin
         noantic_q <= i_wdata[dwg_pkg::NOANTIC_BIT];
      end
   end

   // Mask and read data; the data stand for exactly one cycle.
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         irq_mask_q <= 1'h0;
         rdata_q <= 32'h00000000;
      end else begin
         if (i_wr && sel_irq_mask) begin
            irq_mask_q <= i_wdata[0:0];
         end
         rdata_q <= rdata_d;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign o_rdata = rdata_q;
   assign o_mem_device = memdev_q;
   assign o_bus_16bit = busw_q;
   assign o_no_anticip_read = noantic_q;
   assign o_protect_on = prot_en_q;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------

   // Every check sleeps through reset, so the values that reset forces
   // are left to the bench, which looks at them after each release.
   default clocking cb @(posedge i_mclk);
   endclocking
   default disable iff (i_rst);

   // ----------------------------------------------------------------
   // Sequences
   // ----------------------------------------------------------------

   // A keyed mode write with the enable at one.
   sequence keyed_on_s;
      i_wr && sel_mode && key_ok && i_wdata[0];
   endsequence

   // A keyed mode write with the enable at zero.
   sequence keyed_off_s;
      i_wr && sel_mode && key_ok && !i_wdata[0];
   endsequence

   // A write to a protected word made while protection is on.
   sequence blocked_wr_s;
      i_wr && sel_protected && o_protect_on;
   endsequence

   // A read strobe aimed at the status register.
   sequence stat_read_s;
      i_rd && sel_stat;
   endsequence

   // A cycle with neither strobe, as a master may leave between accesses.
   sequence bus_idle_s;
      !i_wr && !i_rd;
   endsequence

   // ----------------------------------------------------------------
   // Properties
   // ----------------------------------------------------------------

   prot_on_key_a:
   assert property (keyed_on_s |=> o_protect_on)
      else $error("keyed enable write did not set protection");

   prot_off_key_a:
   assert property (keyed_off_s |=> !o_protect_on)
      else $error("keyed disable write did not clear protection");

   bad_key_hold_a:
   assert property (i_wr && sel_mode && !key_ok
                    |=> o_protect_on == $past(o_protect_on))
      else $error("mode write with wrong key changed protection");

   key_reads_zero_a:
   assert property (i_rd && sel_mode |=> o_rdata[31:1] == 31'h0)
      else $error("key field did not read as zero");

   viol_flag_set_a:
   assert property (blocked_wr_s ##1 bus_idle_s ##1 stat_read_s
                    |=> o_rdata[dwg_pkg::VIOL_FLAG_BIT])
      else $error("violation flag missing on status read");

   // The expected source is worked out from the raw address, so a slip
   // in the offset arithmetic above would show up here.
   viol_src_code_a:
   assert property (blocked_wr_s ##1 bus_idle_s ##1 stat_read_s
                    |=> o_rdata[23:8]
                    == $past(i_addr[15:0] - dwg_pkg::CTRL_BASE[15:0], 3))
      else $error("violation source does not name target offset");

   stat_read_clear_a:
   assert property (stat_read_s ##1 !viol_event ##1 stat_read_s
                    |=> o_rdata == 32'h00000000)
      else $error("status read did not clear the status register");

   stat_fields_clear_a:
   assert property (stat_rd && !viol_event
                    |=> !viol_flag_q && viol_src_q == 16'h0000)
      else $error("status read left a field standing");

   flag_quiet_a:
   assert property (i_rd && sel_stat ##1 !viol_event [*2]
                    ##0 i_rd && sel_stat |=> !o_rdata[0])
      else $error("violation flag set without a violation");

   viol_flag_now_a:
   assert property (viol_event |=> viol_flag_q && irq_stat_q[0])
      else $error("refused write was not recorded");

   mode_no_viol_a:
   assert property (i_wr && sel_mode |=> $stable(viol_flag_q))
      else $error("mode register write raised a violation");

   prot_hold_a:
   assert property (!(i_wr && sel_mode) |=> $stable(o_protect_on))
      else $error("protection changed without a mode write");

   blocked_cfg_a:
   assert property (blocked_wr_s |=> $stable(o_mem_device)
                    && $stable(o_bus_16bit) && $stable(o_no_anticip_read))
      else $error("protected register changed while protection on");

   open_cfg_a:
   assert property (i_wr && sel_hispeed && !o_protect_on
                    |=> o_no_anticip_read == $past(i_wdata[2]))
      else $error("unprotected write was not accepted");

   open_memdev_a:
   assert property (i_wr && sel_memdev && !o_protect_on
                    |=> o_mem_device == $past(i_wdata[2:0])
                    && o_bus_16bit == $past(i_wdata[dwg_pkg::BUSW_BIT]))
      else $error("unprotected device write was not accepted");

   // Read data must fall back to zero so that a stale word is never
   // mistaken for a fresh answer by a master that samples late.
   rdata_idle_a:
   assert property (!i_rd |=> o_rdata == 32'h00000000)
      else $error("read data stood longer than one cycle");

   irq_level_a:
   assert property ((blocked_wr_s and irq_mask_q[0]) |=> o_irq)
      else $error("unmasked violation did not raise interrupt");

   irq_masked_a:
   assert property (!irq_mask_q[0] |-> !o_irq)
      else $error("masked violation raised the interrupt");

   irq_clear_a:
   assert property (i_wr && sel_irq_stat && i_wdata[dwg_pkg::IRQ_VIOL_BIT]
                    |=> !o_irq)
      else $error("writing one did not clear the interrupt");

endmodule

`default_nettype wire

//--- verilog/dwg_pkg.sv
package dwg_pkg;

   // ----------------------------------------------------------------
   // Bus geometry
   // ----------------------------------------------------------------
   localparam int unsigned ADDR_W = 32;
   localparam int unsigned DATA_W = 32;

   // ----------------------------------------------------------------
   // Register byte addresses
   // ----------------------------------------------------------------
   localparam logic [31:0] CTRL_BASE = 32'hffffe800;
   localparam logic [31:0] MEMDEV_ADDR = 32'hffffe820;
   localparam logic [31:0] HISPEED_ADDR = 32'hffffe82c;
   localparam logic [31:0] PROT_MODE_ADDR = 32'hffffe8e4;
   localparam logic [31:0] PROT_STAT_ADDR = 32'hffffe8e8;
   localparam logic [31:0] IRQ_STAT_ADDR = 32'hffffe8f0;
   localparam logic [31:0] IRQ_MASK_ADDR = 32'hffffe8f4;

   // ----------------------------------------------------------------
   // Protection mode register fields
   // ----------------------------------------------------------------
   localparam int unsigned PROT_EN_BIT = 0;
   localparam int unsigned KEY_LSB = 8;
   localparam int unsigned KEY_W = 24;
   localparam logic [23:0] KEY_PASSWORD = 24'h444452;
   localparam logic PROT_EN_RESET = 1'b0;

   // ----------------------------------------------------------------
   // Protection status register fields
   // ----------------------------------------------------------------
   localparam int unsigned VIOL_FLAG_BIT = 0;
   localparam int unsigned VIOL_SRC_LSB = 8;
   localparam int unsigned VIOL_SRC_W = 16;

   // ----------------------------------------------------------------
   // Protected configuration fields and reset values
   // ----------------------------------------------------------------
   localparam int unsigned MEMDEV_LSB = 0;
   localparam int unsigned MEMDEV_W = 3;
   localparam logic [2:0] MEMDEV_RESET = 3'h0;
   localparam int unsigned BUSW_BIT = 4;
   localparam logic BUSW_RESET = 1'b1;
   localparam int unsigned NOANTIC_BIT = 2;
   localparam logic NOANTIC_RESET = 1'b1;

   // ----------------------------------------------------------------
   // Interrupt bits
   // ----------------------------------------------------------------
   localparam int unsigned IRQ_VIOL_BIT = 0;
   localparam int unsigned IRQ_W = 1;

endpackage

//--- verification/dwg_write_guard_tb.sv
`timescale 1ns/10ps
`default_nettype none

module dwg_write_guard_tb;

   // ----------------------------------------------------------------
   // Signals and counters
   // ----------------------------------------------------------------
   logic i_mclk;
   logic i_rst;
   logic [31:0] i_addr;
   logic [31:0] i_wdata;
   logic i_wr;
   logic i_rd;
   logic [31:0] o_rdata;
   logic [2:0] o_mem_device;
   logic o_bus_16bit;
   logic o_no_anticip_read;
   logic o_protect_on;
   logic o_irq;
   int fail_count = 0;
   int n_checks = 0;
   int cyc = 0;
   logic [31:0] rv;
   logic [31:0] key_on;
   logic [31:0] key_off;
   logic [31:0] stat_hs;

   dwg_write_guard dut (
      .i_mclk(i_mclk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
      .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
      .o_mem_device(o_mem_device), .o_bus_16bit(o_bus_16bit),
      .o_no_anticip_read(o_no_anticip_read), .o_protect_on(o_protect_on),
      .o_irq(o_irq)
   );

   // Free-running 100 MHz clock.
   initial begin
      i_mclk = 1'b0;
      forever #5 i_mclk = ~i_mclk;
   end

   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   // Prints the counts and the verdict, then stops the run.
   task automatic end_sim();
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("mismatch at %0t got %h expected %h", $time, got, exp);
      end
   endtask

   // One-cycle write strobe; the effect is settled one step after the edge.
   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      @(posedge i_mclk);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_mclk);
      i_wr <= 1'b0;
      #1;
   endtask

   // Read data is valid only in the cycle after the strobe.
   task automatic rd(input logic [31:0] a, output logic [31:0] d);
      @(posedge i_mclk);
      i_rd <= 1'b1;
      i_addr <= a;
      @(posedge i_mclk);
      i_rd <= 1'b0;
      #1;
      d = o_rdata;
   endtask

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   // Reset values, unmapped read, and writes accepted while unprotected.
   task automatic t_open();
      chk({27'h0, o_mem_device, o_bus_16bit, o_no_anticip_read}, 32'h3);
      chk({30'h0, o_protect_on, o_irq}, 32'h0);
      rd(32'hffffe8fc, rv);
      chk(rv, 32'h0);
      wr(dwg_pkg::MEMDEV_ADDR, 32'h0000_0004);
      chk({28'h0, o_bus_16bit, o_mem_device}, 32'h4);
      wr(dwg_pkg::HISPEED_ADDR, 32'h0);
      chk({31'h0, o_no_anticip_read}, 32'h0);
      rd(dwg_pkg::PROT_STAT_ADDR, rv);
      chk(rv, 32'h0);
   endtask

   // A wrong key leaves protection off; the correct key turns it on.
   task automatic t_enable();
      wr(dwg_pkg::PROT_MODE_ADDR, key_on ^ 32'h0000_0100);
      chk({31'h0, o_protect_on}, 32'h0);
      rd(dwg_pkg::PROT_MODE_ADDR, rv);
      chk(rv, 32'h0);
      wr(dwg_pkg::PROT_MODE_ADDR, key_on);
      chk({31'h0, o_protect_on}, 32'h1);
      rd(dwg_pkg::PROT_MODE_ADDR, rv);
      chk(rv, 32'h1);
   endtask

   // Two refused writes, one idle cycle apart: latest source wins, read clears status.
   task automatic t_violate();
      wr(dwg_pkg::IRQ_MASK_ADDR, 32'h1);
      wr(dwg_pkg::MEMDEV_ADDR, 32'h0000_0013);
      chk({28'h0, o_bus_16bit, o_mem_device}, 32'h4);
      chk({31'h0, o_irq}, 32'h1);
      wr(dwg_pkg::HISPEED_ADDR, 32'h0000_0004);
      chk({31'h0, o_no_anticip_read}, 32'h0);
      rd(dwg_pkg::PROT_STAT_ADDR, rv);
      chk(rv, stat_hs);
      rd(dwg_pkg::PROT_STAT_ADDR, rv);
      chk(rv, 32'h0);
      rd(dwg_pkg::IRQ_STAT_ADDR, rv);
      chk(rv, 32'h1);
      wr(dwg_pkg::IRQ_STAT_ADDR, 32'h1);
      chk({31'h0, o_irq}, 32'h0);
      wr(dwg_pkg::IRQ_MASK_ADDR, 32'h0);
      wr(dwg_pkg::HISPEED_ADDR, 32'h0000_0004);
      chk({31'h0, o_irq}, 32'h0);
      rd(dwg_pkg::PROT_STAT_ADDR, rv);
      chk(rv, stat_hs);
      wr(dwg_pkg::IRQ_STAT_ADDR, 32'h1);
   endtask

   // A wrong key cannot switch protection off; the correct key can.
   task automatic t_disable();
      wr(dwg_pkg::PROT_MODE_ADDR, key_off ^ 32'h8000_0000);
      chk({31'h0, o_protect_on}, 32'h1);
      wr(dwg_pkg::PROT_MODE_ADDR, key_off);
      chk({31'h0, o_protect_on}, 32'h0);
      wr(dwg_pkg::HISPEED_ADDR, 32'h0000_0004);
      chk({31'h0, o_no_anticip_read}, 32'h1);
      rd(dwg_pkg::PROT_STAT_ADDR, rv);
      chk(rv, 32'h0);
   endtask

   // A mid-run reset must drop protection, a pending violation and the
   // configuration back to their reset values.
   task automatic t_reset();
      wr(dwg_pkg::PROT_MODE_ADDR, key_on);
      wr(dwg_pkg::MEMDEV_ADDR, 32'h0000_0001);
      chk({28'h0, o_bus_16bit, o_mem_device}, 32'h4);
      @(posedge i_mclk);
      i_rst <= 1'b1;
      repeat (3) @(posedge i_mclk);
      i_rst <= 1'b0;
      #1;
      chk({27'h0, o_mem_device, o_bus_16bit, o_no_anticip_read}, 32'h3);
      chk({30'h0, o_protect_on, o_irq}, 32'h0);
      rd(dwg_pkg::PROT_STAT_ADDR, rv);
      chk(rv, 32'h0);
      rd(dwg_pkg::IRQ_STAT_ADDR, rv);
      chk(rv, 32'h0);
   endtask

   // ----------------------------------------------------------------
   // Main sequence and hang guard
   // ----------------------------------------------------------------
   // Inputs are quiet from time zero and reset spans three cycles.
   initial begin
      i_rst = 1'b1;
      i_addr = 32'h0;
      i_wdata = 32'h0;
      i_wr = 1'b0;
      i_rd = 1'b0;
      key_on = {dwg_pkg::KEY_PASSWORD, 8'h01};
      key_off = {dwg_pkg::KEY_PASSWORD, 8'h00};
      stat_hs = {8'h00, 16'(dwg_pkg::HISPEED_ADDR - dwg_pkg::CTRL_BASE),
                 8'h01};
      repeat (3) @(posedge i_mclk);
      i_rst <= 1'b0;
      #1;
      t_open();
      t_enable();
      t_violate();
      t_disable();
      t_reset();
      end_sim();
   end

   // The whole run needs about sixty cycles; a hang is cut at 2000.
   always @(posedge i_mclk) begin
      cyc <= cyc + 1;
      if (cyc == 2000) begin
         fail_count++;
         end_sim();
      end
   end

endmodule

`default_nettype wire
